// [include/odl_pkg.sv]
// constants, field layouts and carrier types of the octal dac serial load control
// assumes a 32-bit frame word and eight channels of straight binary codes
package odl_pkg;

	localparam int unsigned ODL_FRAME_BITS  = 32;
	localparam int unsigned ODL_CHANNELS    = 8;
	localparam int unsigned ODL_DAC_BITS    = 12;
	localparam int unsigned ODL_DATA_BITS   = 16;
	localparam int unsigned ODL_CNT_BITS    = 6;
	localparam int unsigned ODL_SYNC_STAGES = 2;

	localparam logic [5:0] ODL_CNT_FULL = 6'h20;
	localparam logic [3:0] ODL_ADDR_ALL = 4'hF;

	// field positions inside the data field
	localparam int unsigned ODL_REF_BIT     = 0;
	localparam int unsigned ODL_CLR_SEL_LSB = 0;
	localparam int unsigned ODL_MASK_LSB    = 0;

	typedef enum logic [3:0] {
		ODL_CMD_WR_IN      = 4'h0,
		ODL_CMD_UPD_DAC    = 4'h1,
		ODL_CMD_WR_UPD_ALL = 4'h2,
		ODL_CMD_WR_UPD     = 4'h3,
		ODL_CMD_PWR_DN     = 4'h4,
		ODL_CMD_CLR_CODE   = 4'h5,
		ODL_CMD_LOAD_STROBE_N_MASK  = 4'h6,
		ODL_CMD_REF_SET    = 4'h7
	} odl_cmd_t;

	typedef enum logic [1:0] {
		ODL_CLR_ZERO = 2'h0,
		ODL_CLR_MID  = 2'h1,
		ODL_CLR_FULL = 2'h2
	} odl_clr_sel_t;

	// reset values
	localparam odl_clr_sel_t ODL_CLR_SEL_RST = ODL_CLR_ZERO;
	localparam logic         ODL_REF_INT_RST = 1'h0;
	localparam logic [7:0]   ODL_MASK_RST    = 8'h00;
	localparam logic [7:0]   ODL_PD_RST      = 8'h00;
	localparam logic [2:0]   ODL_PINS_RST    = 3'h7;

	typedef struct packed {
		logic [3:0]  spare_hi;
		logic [3:0]  cmd;
		logic [3:0]  addr;
		logic [15:0] data;
		logic [3:0]  spare_lo;
	} odl_frame_t;

	typedef struct packed {
		logic sync_n;
		logic load_strobe_n;
		logic clear_n;
	} odl_pins_t;

endpackage : odl_pkg

// [src/odl_sync.sv]
// two-flop level synchroniser, any width
// assumes each bit is an independent level from another domain
`timescale 1ns/1ns
module odl_sync #(
	parameter int unsigned W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	// levels
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	import odl_pkg::*;

	logic [W-1:0] meta;

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			meta <= RST_VAL;
			q_o  <= RST_VAL;
		end
		else
		begin
			meta <= d_i;
			q_o  <= meta;
		end
	end

endmodule : odl_sync

// [src/odl_link.sv]
// serial link front end on the shift clock: bit counter, shifter, word hand-off
// assumes the host drives the shift clock only inside frames
`timescale 1ns/1ns
module odl_link (
	// link clock and reset
	input  wire logic               sclk_i,
	input  wire logic               reset_i,
	// link pins
	input  wire logic               sync_n_i,
	input  wire logic               din_i,
	// completed word, held stable until the next completion
	output odl_pkg::odl_frame_t     frame_o,
	output logic                    done_tgl_o
);
	import odl_pkg::*;

	logic [ODL_CNT_BITS-1:0]   bit_cnt;
	logic [ODL_FRAME_BITS-1:0] shift;

	wire frame_on  = ~sync_n_i;
	wire shifting  = frame_on && (bit_cnt != ODL_CNT_FULL);
	wire last_edge = shifting && (bit_cnt == ODL_CNT_FULL - 6'h01);
	wire [ODL_FRAME_BITS-1:0] next_shift = {shift[ODL_FRAME_BITS-2:0], din_i};

	// frame select high clears the count, so a partial word is never handed on
	always_ff @(negedge sclk_i or posedge sync_n_i or posedge reset_i)
	begin
		if (sync_n_i || reset_i)
			bit_cnt <= '0;
		else if (shifting)
			bit_cnt <= bit_cnt + 6'h01;
	end

	always_ff @(negedge sclk_i)
	begin
		if (shifting)
			shift <= next_shift;
	end

	always_ff @(negedge sclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			frame_o    <= '0;
			done_tgl_o <= 1'h0;
		end
		else if (last_edge)
		begin
			frame_o    <= next_shift;
			done_tgl_o <= ~done_tgl_o;
		end
	end

endmodule : odl_link

// [src/odl_top.sv]
// octal dac serial load control: link front end, command decode,
// per-channel input and dac registers, load strobe and clear handling
// assumes pins are asynchronous to mclk_i and the shift clock runs only in frames
`timescale 1ns/1ns
module odl_top #(
	parameter int unsigned DAC_BITS = odl_pkg::ODL_DAC_BITS,
	parameter int unsigned CHANNELS = odl_pkg::ODL_CHANNELS
) (
	// system clock and reset
	input  wire logic                mclk_i,
	input  wire logic                reset_i,
	// serial link
	input  wire logic                sclk_i,
	input  wire logic                sync_n_i,
	input  wire logic                din_i,
	// strobes
	input  wire logic                load_strobe_n_i,
	input  wire logic                clear_n_i,
	// dac codes and analog control
	output logic [CHANNELS-1:0][DAC_BITS-1:0] dac_code_o,
	output logic [CHANNELS-1:0][DAC_BITS-1:0] input_code_o,
	output logic [CHANNELS-1:0]      power_down_o,
	output logic                     ref_internal_o,
	output logic                     ref_drive_n_o,
	// link status
	output logic                     input_buf_en_o,
	output logic                     frame_done_o,
	output logic                     frame_abort_o
);
	import odl_pkg::*;

	// link side
	odl_frame_t link_frame;
	logic       link_tgl;

	odl_link u_link (
		.sclk_i     (sclk_i),
		.reset_i    (reset_i),
		.sync_n_i   (sync_n_i),
		.din_i      (din_i),
		.frame_o    (link_frame),
		.done_tgl_o (link_tgl)
	);

	// crossings into mclk
	odl_pins_t pins_raw;
	odl_pins_t pins_s;
	odl_pins_t pins_q;
	logic      tgl_s;
	logic      tgl_q;

	assign pins_raw.sync_n        = sync_n_i;
	assign pins_raw.load_strobe_n = load_strobe_n_i;
	assign pins_raw.clear_n       = clear_n_i;

	odl_sync #(
		.W       (3),
		.RST_VAL (ODL_PINS_RST)
	) u_pin_sync (
		.clk_i   (mclk_i),
		.reset_i (reset_i),
		.d_i     (pins_raw),
		.q_o     (pins_s)
	);

	odl_sync #(
		.W       (1),
		.RST_VAL (1'h0)
	) u_tgl_sync (
		.clk_i   (mclk_i),
		.reset_i (reset_i),
		.d_i     (link_tgl),
		.q_o     (tgl_s)
	);

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			pins_q <= ODL_PINS_RST;
			tgl_q  <= 1'h0;
		end
		else
		begin
			pins_q <= pins_s;
			tgl_q  <= tgl_s;
		end
	end

	// events
	wire word_evt  = tgl_s ^ tgl_q;
	wire sync_fall = pins_q.sync_n & ~pins_s.sync_n;
	wire sync_rise = ~pins_q.sync_n & pins_s.sync_n;
	wire clr_fall  = pins_q.clear_n & ~pins_s.clear_n;
	wire load_strobe_n_on   = ~pins_s.load_strobe_n & pins_s.clear_n;

	// decode of the completed word, read only on word_evt while it is stable
	odl_cmd_t   cmd;
	wire [3:0]  addr = link_frame.addr;
	wire [15:0] data = link_frame.data;
	wire [DAC_BITS-1:0] data_code = data[ODL_DATA_BITS-1 -: DAC_BITS];

	assign cmd = odl_cmd_t'(link_frame.cmd);

	wire is_wr_in      = word_evt && (cmd == ODL_CMD_WR_IN);
	wire is_upd_dac    = word_evt && (cmd == ODL_CMD_UPD_DAC);
	wire is_wr_upd_all = word_evt && (cmd == ODL_CMD_WR_UPD_ALL);
	wire is_wr_upd     = word_evt && (cmd == ODL_CMD_WR_UPD);
	wire is_pwr_dn     = word_evt && (cmd == ODL_CMD_PWR_DN);
	wire is_clr_code   = word_evt && (cmd == ODL_CMD_CLR_CODE);
	wire is_mask       = word_evt && (cmd == ODL_CMD_LOAD_STROBE_N_MASK);
	wire is_ref_set    = word_evt && (cmd == ODL_CMD_REF_SET);
	wire any_write     = is_wr_in || is_wr_upd_all || is_wr_upd;

	// control settings
	odl_clr_sel_t        clr_sel;
	logic [CHANNELS-1:0] load_strobe_n_mask;
	logic [CHANNELS-1:0] pd;
	logic                ref_int;
	logic                frame_open;

	wire [CHANNELS-1:0] pd_req = data[ODL_MASK_LSB +: CHANNELS];
	wire [CHANNELS-1:0] next_pd = ref_int ? {CHANNELS{|pd_req}} : pd_req;
	wire                next_ref_int = data[ODL_REF_BIT];
	wire [CHANNELS-1:0] pd_on_ref = {CHANNELS{|pd}};
	odl_clr_sel_t       next_clr_sel;

	assign next_clr_sel = odl_clr_sel_t'(data[ODL_CLR_SEL_LSB +: 2]);

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
			clr_sel <= ODL_CLR_SEL_RST;
		else if (is_clr_code)
			clr_sel <= next_clr_sel;
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
			load_strobe_n_mask <= ODL_MASK_RST;
		else if (is_mask)
			load_strobe_n_mask <= data[ODL_MASK_LSB +: CHANNELS];
	end

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
			ref_int <= ODL_REF_INT_RST;
		else if (is_ref_set)
			ref_int <= next_ref_int;
	end

	// selecting the internal reference also merges any split power-down
	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
			pd <= ODL_PD_RST;
		else if (is_pwr_dn)
			pd <= next_pd;
		else if (is_ref_set && next_ref_int)
			pd <= pd_on_ref;
	end

	// clear code value
	logic [DAC_BITS-1:0] clr_code;

	always_comb
	begin
		case (clr_sel)
			ODL_CLR_ZERO: clr_code = '0;
			ODL_CLR_MID:  clr_code = {1'b1, {(DAC_BITS-1){1'b0}}};
			ODL_CLR_FULL: clr_code = '1;
			default:      clr_code = '0;
		endcase
	end

	// per-channel input and dac registers
	logic [CHANNELS-1:0][DAC_BITS-1:0] in_reg;
	logic [CHANNELS-1:0][DAC_BITS-1:0] dac_reg;
	logic [CHANNELS-1:0]               pending;

	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++)
		begin : g_chan
			wire sel = (addr == ODL_ADDR_ALL) || (addr == 4'(ch));
			wire wr  = any_write && sel;
			wire upd = (is_upd_dac && sel) || is_wr_upd_all || (is_wr_upd && sel);
			wire hw  = load_strobe_n_on && !load_strobe_n_mask[ch] && pending[ch];
			wire [DAC_BITS-1:0] in_now = wr ? data_code : in_reg[ch];

			logic [DAC_BITS-1:0] next_in;
			logic [DAC_BITS-1:0] next_dac;
			logic                next_pend;

			always_comb
			begin
				next_in   = in_reg[ch];
				next_dac  = dac_reg[ch];
				next_pend = pending[ch];
				if (clr_fall)
				begin
					next_in   = clr_code;
					next_dac  = clr_code;
					next_pend = 1'b0;
				end
				else
				begin
					if (wr)
					begin
						next_in   = data_code;
						next_pend = 1'b1;
					end
					if (upd)
					begin
						next_dac  = in_now;
						next_pend = 1'b0;
					end
					else if (hw)
					begin
						next_dac  = in_reg[ch];
						next_pend = wr;
					end
				end
			end

			always_ff @(posedge mclk_i or posedge reset_i)
			begin
				if (reset_i)
				begin
					in_reg[ch]  <= '0;
					dac_reg[ch] <= '0;
					pending[ch] <= 1'b0;
				end
				else
				begin
					in_reg[ch]  <= next_in;
					dac_reg[ch] <= next_dac;
					pending[ch] <= next_pend;
				end
			end
		end
	endgenerate

	assign dac_code_o   = dac_reg;
	assign input_code_o = in_reg;
	assign power_down_o = pd;

	// frame tracking: abort when frame select rises before a word arrived
	wire next_open  = sync_fall ? 1'b1 : ((word_evt || sync_rise) ? 1'b0 : frame_open);
	wire next_abort = sync_rise && frame_open && !word_evt;

	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
			frame_open <= 1'b0;
		else
			frame_open <= next_open;
	end

	// status and analog control outputs
	always_ff @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			input_buf_en_o <= 1'b0;
			frame_done_o   <= 1'b0;
			frame_abort_o  <= 1'b0;
			ref_internal_o <= ODL_REF_INT_RST;
			ref_drive_n_o  <= 1'b1;
		end
		else
		begin
			input_buf_en_o <= ~pins_s.sync_n;
			frame_done_o   <= word_evt;
			frame_abort_o  <= next_abort;
			ref_internal_o <= ref_int;
			ref_drive_n_o  <= ~ref_int;
		end
	end

endmodule : odl_top

// [testbench/odl_host.sv]
// host serial controller model: frame select, shift clock and serial data
// assumes a 30 ns shift clock that stands high outside frames
`timescale 1ns/1ns
module odl_host (
	// link pins
	output logic sclk_o,
	output logic sync_n_o,
	output logic din_o
);
	initial
	begin
		sclk_o = 1'b1;
		sync_n_o = 1'b1;
		din_o = 1'b0;
	end

	// n falling edges, msb first; fewer than 32 gives an aborted frame
	task automatic send(input logic [31:0] w, input int n);
		#3;
		sync_n_o = 1'b0;
		#15;
		for (int i = 0; i < n; i++)
		begin
			din_o = w[31 - (i % 32)];
			#15;
			sclk_o = 1'b0;
			#15;
			sclk_o = 1'b1;
		end
		#5;
		sync_n_o = 1'b1;
		din_o = ~din_o;
		#20;
	endtask : send
endmodule : odl_host

// [testbench/odl_top_asserts.sv]
// checker of odl_top pin relations in the mclk_i domain
// assumes it is bound to odl_top and sees only its ports
`timescale 1ns/1ns
module odl_top_asserts
	import odl_pkg::*;
#(
	parameter int unsigned DAC_BITS = ODL_DAC_BITS,
	parameter int unsigned CHANNELS = ODL_CHANNELS
) (
	// clock, reset and pins
	input wire logic                              mclk_i,
	input wire logic                              reset_i,
	input wire logic                              sync_n_i,
	input wire logic                              load_strobe_n_i,
	input wire logic                              clear_n_i,
	// outputs
	input wire logic [CHANNELS-1:0][DAC_BITS-1:0] dac_code_o,
	input wire logic [CHANNELS-1:0][DAC_BITS-1:0] input_code_o,
	input wire logic [CHANNELS-1:0]               power_down_o,
	input wire logic                              ref_internal_o,
	input wire logic                              ref_drive_n_o,
	input wire logic                              input_buf_en_o,
	input wire logic                              frame_done_o,
	input wire logic                              frame_abort_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (reset_i);

	property p_abort_keeps;
		frame_abort_o |-> $stable(input_code_o) && $stable(dac_code_o) && !frame_done_o;
	endproperty
	a_abort_keeps: assert property (p_abort_keeps) else $error("abort changed codes");
	property p_buf_on;
		$fell(sync_n_i) |-> ##[1:4] input_buf_en_o;
	endproperty
	a_buf_on: assert property (p_buf_on) else $error("buffers not enabled");
	property p_buf_off;
		sync_n_i [*5] |-> !input_buf_en_o;
	endproperty
	a_buf_off: assert property (p_buf_off) else $error("buffers on outside frame");
	property p_strobe_idle;
		(load_strobe_n_i && clear_n_i) [*6] ##0 !frame_done_o |-> $stable(dac_code_o);
	endproperty
	a_strobe_idle: assert property (p_strobe_idle) else $error("dac moved without cause");
	property p_clr_blocks;
		(!clear_n_i [*6]) ##0 !frame_done_o |-> $stable(dac_code_o);
	endproperty
	a_clr_blocks: assert property (p_clr_blocks) else $error("transfer during clear");
	property p_clr_load;
		$fell(clear_n_i) |-> ##[2:5] (dac_code_o == input_code_o
			&& dac_code_o[0] == dac_code_o[CHANNELS-1]);
	endproperty
	a_clr_load: assert property (p_clr_load) else $error("clear code not loaded");
	property p_ref_pin;
		!ref_internal_o |-> ref_drive_n_o;
	endproperty
	a_ref_pin: assert property (p_ref_pin) else $error("reference pin driven");
	property p_ref_on;
		$rose(ref_internal_o) |-> $past(frame_done_o);
	endproperty
	a_ref_on: assert property (p_ref_on) else $error("reference on without write");
	property p_pd_merge;
		ref_internal_o && (|power_down_o) |-> (&power_down_o);
	endproperty
	a_pd_merge: assert property (p_pd_merge) else $error("single channel powered down");
	property p_done_once;
		frame_done_o |=> !frame_done_o [*5];
	endproperty
	a_done_once: assert property (p_done_once) else $error("word decoded twice");
endmodule : odl_top_asserts

bind odl_top odl_top_asserts #(
	.DAC_BITS(DAC_BITS),
	.CHANNELS(CHANNELS)
) u_chk (
	.mclk_i         (mclk_i),
	.reset_i        (reset_i),
	.sync_n_i       (sync_n_i),
	.load_strobe_n_i(load_strobe_n_i),
	.clear_n_i      (clear_n_i),
	.dac_code_o     (dac_code_o),
	.input_code_o   (input_code_o),
	.power_down_o   (power_down_o),
	.ref_internal_o (ref_internal_o),
	.ref_drive_n_o  (ref_drive_n_o),
	.input_buf_en_o (input_buf_en_o),
	.frame_done_o   (frame_done_o),
	.frame_abort_o  (frame_abort_o)
);

// [testbench/octal_dac_serial_load_control_test.sv]
// self-checking bench of odl_top: table of writes, then strobe, abort, clear, reference, reset again
// assumes odl_host drives the link and the checker is bound to odl_top
`timescale 1ns/1ns
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin error_cnt++; \
	$display("unexpected %s exp %h got %h", nm, (e), (a)); end end
module octal_dac_serial_load_control_test;
	import odl_pkg::*;
	typedef struct {
		logic [31:0] w;
		int          ch;
		logic [11:0] ei;
		logic [11:0] ed;
	} odl_row_t;
	odl_row_t    rows [5] = '{'{32'h002ABC00, 2, 12'hABC, 12'h000},
		'{32'h035FFF00, 5, 12'hFFF, 12'hFFF}, '{32'h01200000, 2, 12'hABC, 12'hABC},
		'{32'h02012300, 0, 12'h123, 12'h123}, '{32'h00F45600, 7, 12'h456, 12'h000}};
	logic [11:0] ccode [4] = '{12'h000, 12'h800, 12'hFFF, 12'h000};
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        ld_n = 1'b1;
	logic        clr_n = 1'b1;
	logic        sclk, sync_n, din, ref_int, ref_drv_n, buf_en, done, abt, pd, pa;
	logic [ODL_CHANNELS-1:0][ODL_DAC_BITS-1:0] dac, inc;
	logic [ODL_CHANNELS-1:0] pdn;
	int          compares = 0;
	int          error_cnt = 0;

	odl_host u_host (.sclk_o(sclk), .sync_n_o(sync_n), .din_o(din));
	odl_top dut (.mclk_i(mclk), .reset_i(rst), .sclk_i(sclk), .sync_n_i(sync_n), .din_i(din),
		.load_strobe_n_i(ld_n), .clear_n_i(clr_n), .dac_code_o(dac), .input_code_o(inc),
		.power_down_o(pdn), .ref_internal_o(ref_int), .ref_drive_n_o(ref_drv_n),
		.input_buf_en_o(buf_en), .frame_done_o(done), .frame_abort_o(abt));

	initial
	begin
		forever #4 mclk = ~mclk;
	end

	task automatic give_verdict;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	task automatic xfer(input logic [31:0] w, input int n);
		pd = 1'b0;
		pa = 1'b0;
		fork
			u_host.send(w, n);
			for (int i = 0; i < 300 && !(pd | pa); i++)
			begin
				@(posedge mclk);
				#1;
				pd = done;
				pa = abt;
			end
		join
		`CHK("handshake", 1'b1, pd | pa)
		repeat (2) @(negedge mclk);
	endtask : xfer

	task automatic pulse(ref logic s);
		@(negedge mclk);
		s = 1'b0;
		repeat (3) @(negedge mclk);
		s = 1'b1;
		repeat (6) @(negedge mclk);
	endtask : pulse

	initial
	begin
		#200000;
		error_cnt++;
		give_verdict();
	end

	initial
	begin
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		repeat (4) @(negedge mclk);
		`CHK("dac", '0, dac)
		`CHK("refint", 1'b0, ref_int)
		`CHK("refdrv", 1'b1, ref_drv_n)
		`CHK("bufen", 1'b0, buf_en)
		$display("test reset done");
		foreach (rows[i])
		begin
			xfer(rows[i].w, 32);
			`CHK("done", 1'b1, pd)
			`CHK("input", rows[i].ei, inc[rows[i].ch])
			`CHK("dac", rows[i].ed, dac[rows[i].ch])
		end
		$display("test table done");
		pulse(ld_n);
		`CHK("dac3", 12'h456, dac[3])
		`CHK("dac7", 12'h456, dac[7])
		xfer(32'h06000080, 32);
		xfer(32'h00F78900, 32);
		pulse(ld_n);
		`CHK("masked", 12'h456, dac[3])
		`CHK("dac4", 12'h789, dac[4])
		$display("test strobe done");
		xfer(32'h00177700, 20);
		`CHK("abort", 1'b1, pa)
		`CHK("inc1", 12'h789, inc[1])
		xfer(32'h03665400, 36);
		`CHK("inc6", 12'h654, inc[6])
		`CHK("dac6", 12'h654, dac[6])
		$display("test frame done");
		pulse(clr_n);
		`CHK("clr dflt", 12'h000, dac[3])
		for (int k = 0; k < 4; k++)
		begin
			xfer(32'h05000000 | (32'(k) << 4), 32);
			pulse(clr_n);
			`CHK("clr dac", ccode[k], dac[k])
			`CHK("clr inc", ccode[k], inc[7-k])
		end
		clr_n = 1'b0;
		repeat (6) @(negedge mclk);
		xfer(32'h00111100, 32);
		pulse(ld_n);
		`CHK("held dac", 12'h000, dac[1])
		`CHK("held inc", 12'h111, inc[1])
		clr_n = 1'b1;
		repeat (6) @(negedge mclk);
		pulse(ld_n);
		`CHK("after", 12'h111, dac[1])
		ld_n = 1'b0;
		xfer(32'h002ABC00, 32);
		`CHK("tied", 12'hABC, dac[2])
		ld_n = 1'b1;
		$display("test clear done");
		xfer(32'h04000010, 32);
		`CHK("pd ext", 8'h01, pdn)
		xfer(32'h07000010, 32);
		`CHK("refint", 1'b1, ref_int)
		`CHK("refdrv", 1'b0, ref_drv_n)
		`CHK("pd int", 8'hFF, pdn)
		$display("test reference done");
		xfer(32'h05000020, 32);
		rst = 1'b1;
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		repeat (2) @(negedge mclk);
		`CHK("rst dac", '0, dac)
		`CHK("rst refint", 1'b0, ref_int)
		`CHK("rst refdrv", 1'b1, ref_drv_n)
		`CHK("rst pd", 8'h00, pdn)
		`CHK("rst bufen", 1'b0, buf_en)
		`CHK("rst done", 1'b0, done)
		repeat (3) @(negedge mclk);
		xfer(32'h035ABC00, 32);
		`CHK("rst wr", 12'hABC, dac[5])
		pulse(clr_n);
		`CHK("rst clr", 12'h000, dac[5])
		`CHK("rst clr inc", 12'h000, inc[5])
		$display("test reset again done");
		give_verdict();
	end
endmodule : octal_dac_serial_load_control_test
